// ===== common/resolver_pkg.sv
package resolver_pkg;
   // =====================================
   // Register offsets
   localparam logic [11:0] OFF_START = 12'h0000;
   localparam logic [11:0] OFF_STOP = 12'h0008;
   localparam logic [11:0] OFF_EV_END = 12'h0100;
   localparam logic [11:0] OFF_EV_RESOLVED = 12'h0104;
   localparam logic [11:0] OFF_EV_UNRESOLVED = 12'h0108;
   localparam logic [11:0] OFF_INT_ENABLE_SET = 12'h0304;
   localparam logic [11:0] OFF_INT_DISABLE = 12'h0308;
   localparam logic [11:0] OFF_STATUS = 12'h0400;
   localparam logic [11:0] OFF_ENABLE = 12'h0500;
   localparam logic [11:0] OFF_KEY_COUNT = 12'h0504;
   localparam logic [11:0] OFF_KEY_PTR = 12'h0508;
   localparam logic [11:0] OFF_ADDR_PTR = 12'h0510;
   localparam logic [11:0] OFF_SCRATCH_PTR = 12'h0514;
   localparam logic [11:0] OFF_PENDING = 12'h0300;
   // =====================================
   // Fields and reset values
   localparam int BIT_END = 0;
   localparam int BIT_RESOLVED = 1;
   localparam int BIT_UNRESOLVED = 2;
   localparam logic [1:0] ENABLE_ON = 2'h3;
   localparam logic [1:0] ENABLE_OFF = 2'h0;
   localparam logic [4:0] KEY_COUNT_RESET = 5'h01;
   localparam logic [4:0] KEY_COUNT_MAX = 5'h10;
   localparam logic [31:0] KEY_STRIDE = 32'h0000_0010;
   localparam logic [31:0] SCRATCH_SPAN = 32'h0000_0010;
   // =====================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int OVERHEAD_US = 1;
   localparam int PER_KEY_NS = 5875;
   localparam int OVERHEAD_CYCLES = OVERHEAD_US * CLK_MHZ;
   localparam int PER_KEY_CYCLES = (PER_KEY_NS * CLK_MHZ) / 1000;
endpackage : resolver_pkg

// ===== hdl/key_matcher.sv
`timescale 1ns/100ps
module key_matcher
   import resolver_pkg::*;
#(
   parameter int CYCLES = PER_KEY_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [47:0] address,
   input wire logic [127:0] key,
   output logic done,
   output logic match
);
   if (CYCLES < 2 || CYCLES > 65537)
   begin : g_bad_cycles
      $error("per-key cycles out of range");
   end
   logic [15:0] count;
   logic busy;
   logic [23:0] hash;
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         busy <= 1'b0;
         count <= 16'h0000;
         done <= 1'b0;
         match <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (start)
         begin
            busy <= 1'b1;
            count <= 16'h0000;
         end
         else if (busy)
         begin
            count <= count + 16'h0001;
            if (count == 16'(CYCLES - 2))
            begin
               busy <= 1'b0;
               done <= 1'b1;
               match <= (hash == address[23:0]);
            end
         end
      end
   end
   // Key-derived hash of the random part
   always_comb
   begin
      hash = key[23:0] ^ key[127:104] ^ {address[47:24]};
   end
endmodule : key_matcher

// ===== hdl/address_resolver.sv
`timescale 1ns/100ps
// Overview of operation
// - Disable write of one clears interrupt enable
// - Disable read returns enables, reset zero
// - Status holds matched key index
// - Enable three turns on, zero off
// - Key count one to sixteen, reset one
// - Keys fetched from key table pointer
// - Address read from address pointer
// - Scratch writes stay inside scratch area
// - Time is overhead plus per-key time
// - Eight keys take about 48 us
// - Stop on match or after count
// - Enable-set write of one enables interrupt
module address_resolver
   import resolver_pkg::*;
#(
   parameter int OVERHEAD = OVERHEAD_CYCLES,
   parameter int KEY_CYCLES = PER_KEY_CYCLES
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq,
   output logic mem_rd,
   output logic mem_wr,
   output logic [31:0] mem_addr,
   output logic [31:0] mem_wdata,
   input wire logic [31:0] mem_rdata,
   input wire logic mem_valid
);
   if (OVERHEAD < 4 || OVERHEAD > 65539 || KEY_CYCLES < 2)
   begin : g_bad_timing
      $error("timing parameters out of range");
   end

   typedef enum logic [2:0] {IDLE, ADDR_LO, ADDR_HI, KEY_FETCH, MATCH, SCRATCH, FINISH} state_t;
   state_t state;

   logic [2:0] int_en, events;
   logic [3:0] status, key_idx;
   logic [1:0] enable, word;
   logic [4:0] key_count;
   logic [31:0] key_ptr, addr_ptr, scratch_ptr;
   logic [47:0] address;
   logic [127:0] key;
   logic [15:0] wait_cnt;
   logic start_req, stop_req, m_start, m_done, m_match;
   logic ev_end, ev_res, ev_unres;
   logic [2:0] ev_set;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a == off;
   endfunction : hit

   assign start_req = wr && hit(addr, OFF_START) && wdata[0];
   assign stop_req = wr && hit(addr, OFF_STOP) && wdata[0];
   assign ev_set = {ev_unres, ev_res, ev_end};

   // =====================================
   // Configuration registers
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         int_en <= 3'h0;
         enable <= ENABLE_OFF;
         key_count <= KEY_COUNT_RESET;
         key_ptr <= 32'h0000_0000;
         addr_ptr <= 32'h0000_0000;
         scratch_ptr <= 32'h0000_0000;
      end
      else if (wr)
      begin
         if (hit(addr, OFF_INT_ENABLE_SET))
            int_en <= int_en | wdata[2:0];
         if (hit(addr, OFF_INT_DISABLE))
            int_en <= int_en & ~wdata[2:0];
         if (hit(addr, OFF_ENABLE))
            enable <= wdata[1:0];
         if (hit(addr, OFF_KEY_COUNT) && wdata[4:0] != 5'h00 && wdata[4:0] <= KEY_COUNT_MAX)
            key_count <= wdata[4:0];
         if (hit(addr, OFF_KEY_PTR))
            key_ptr <= wdata;
         if (hit(addr, OFF_ADDR_PTR))
            addr_ptr <= wdata;
         if (hit(addr, OFF_SCRATCH_PTR))
            scratch_ptr <= wdata;
      end
   end

   // =====================================
   // Event flags, set wins over clear
   always_ff @(posedge core_clk)
   begin
      if (rst)
         events <= 3'h0;
      else if (rd && hit(addr, OFF_PENDING))
         events <= ev_set;
      else
      begin
         if (rd && hit(addr, OFF_EV_END))
            events[BIT_END] <= ev_end;
         else if (ev_end)
            events[BIT_END] <= 1'b1;
         if (rd && hit(addr, OFF_EV_RESOLVED))
            events[BIT_RESOLVED] <= ev_res;
         else if (ev_res)
            events[BIT_RESOLVED] <= 1'b1;
         if (rd && hit(addr, OFF_EV_UNRESOLVED))
            events[BIT_UNRESOLVED] <= ev_unres;
         else if (ev_unres)
            events[BIT_UNRESOLVED] <= 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(events & int_en);
   end

   // =====================================
   // Read data
   always_ff @(posedge core_clk)
   begin
      if (rst || !rd)
         rdata <= 32'h0000_0000;
      else
      begin
         unique case (addr)
            OFF_EV_END: rdata <= {31'h0, events[BIT_END]};
            OFF_EV_RESOLVED: rdata <= {31'h0, events[BIT_RESOLVED]};
            OFF_EV_UNRESOLVED: rdata <= {31'h0, events[BIT_UNRESOLVED]};
            OFF_PENDING: rdata <= {29'h0, events};
            OFF_INT_ENABLE_SET, OFF_INT_DISABLE: rdata <= {29'h0, int_en};
            OFF_STATUS: rdata <= {28'h0, status};
            OFF_ENABLE: rdata <= {30'h0, enable};
            OFF_KEY_COUNT: rdata <= {27'h0, key_count};
            OFF_KEY_PTR: rdata <= key_ptr;
            OFF_ADDR_PTR: rdata <= addr_ptr;
            OFF_SCRATCH_PTR: rdata <= scratch_ptr;
            default: rdata <= 32'h0000_0000;
         endcase
      end
   end

   // =====================================
   // Resolution sequencer
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state <= IDLE;
         status <= 4'h0;
         word <= 2'h0;
         key_idx <= 4'h0;
         wait_cnt <= 16'h0000;
         address <= 48'h0;
         key <= 128'h0;
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         mem_addr <= 32'h0000_0000;
         mem_wdata <= 32'h0000_0000;
         m_start <= 1'b0;
         ev_end <= 1'b0;
         ev_res <= 1'b0;
         ev_unres <= 1'b0;
      end
      else
      begin
         mem_rd <= 1'b0;
         mem_wr <= 1'b0;
         m_start <= 1'b0;
         ev_end <= 1'b0;
         ev_res <= 1'b0;
         ev_unres <= 1'b0;
         if (stop_req && state != IDLE)
         begin
            state <= IDLE;
            ev_end <= 1'b1;
         end
         else
         begin
            unique case (state)
               IDLE:
                  if (start_req && enable == ENABLE_ON)
                  begin
                     state <= ADDR_LO;
                     wait_cnt <= 16'(OVERHEAD - 4);
                     key_idx <= 4'h0;
                     mem_rd <= 1'b1;
                     mem_addr <= addr_ptr;
                  end
               ADDR_LO:
                  if (mem_valid)
                  begin
                     address[31:0] <= mem_rdata;
                     mem_rd <= 1'b1;
                     mem_addr <= addr_ptr + 32'h0000_0004;
                     state <= ADDR_HI;
                  end
               ADDR_HI:
                  if (mem_valid)
                  begin
                     address[47:32] <= mem_rdata[15:0];
                     state <= SCRATCH;
                     mem_wr <= 1'b1;
                     mem_addr <= scratch_ptr;
                     mem_wdata <= {16'h0000, mem_rdata[15:0]};
                  end
               SCRATCH:
                  if (wait_cnt != 16'h0000)
                     wait_cnt <= wait_cnt - 16'h0001;
                  else
                  begin
                     state <= KEY_FETCH;
                     word <= 2'h0;
                     mem_rd <= 1'b1;
                     mem_addr <= key_ptr + KEY_STRIDE * {28'h0, key_idx};
                  end
               KEY_FETCH:
                  if (mem_valid)
                  begin
                     key <= {mem_rdata, key[127:32]};
                     word <= word + 2'h1;
                     if (word == 2'h3)
                     begin
                        state <= MATCH;
                        m_start <= 1'b1;
                     end
                     else
                     begin
                        mem_rd <= 1'b1;
                        mem_addr <= key_ptr + KEY_STRIDE * {28'h0, key_idx} + {28'h0, word + 2'h1, 2'h0};
                     end
                  end
               MATCH:
                  if (m_done)
                  begin
                     if (m_match)
                     begin
                        status <= key_idx;
                        ev_res <= 1'b1;
                        state <= FINISH;
                     end
                     else if ({1'b0, key_idx} + 5'h01 >= key_count)
                     begin
                        ev_unres <= 1'b1;
                        state <= FINISH;
                     end
                     else
                     begin
                        key_idx <= key_idx + 4'h1;
                        state <= KEY_FETCH;
                        word <= 2'h0;
                        mem_rd <= 1'b1;
                        mem_addr <= key_ptr + KEY_STRIDE * {28'h0, key_idx + 4'h1};
                     end
                  end
               FINISH:
               begin
                  ev_end <= 1'b1;
                  state <= IDLE;
               end
            endcase
         end
      end
   end

   key_matcher #(.CYCLES(KEY_CYCLES)) matcher (
      .core_clk(core_clk),
      .rst(rst),
      .start(m_start),
      .address(address),
      .key(key),
      .done(m_done),
      .match(m_match)
   );

   // =====================================
   // Checks
   sequence s_result;
      ev_res || ev_unres;
   endsequence
   sequence s_finish;
      ##1 ev_end;
   endsequence

   a_disable_clears: assert property (@(posedge core_clk) disable iff (rst)
      wr && hit(addr, OFF_INT_DISABLE) && wdata[0] |=> !int_en[0])
      else $error("disable write did not clear enable");
   a_enable_sets: assert property (@(posedge core_clk) disable iff (rst)
      wr && hit(addr, OFF_INT_ENABLE_SET) && wdata[1] |=> int_en[1])
      else $error("enable-set write did not set enable");
   a_enable_readback: assert property (@(posedge core_clk) disable iff (rst)
      rd && hit(addr, OFF_INT_DISABLE) |=> rdata[2:0] == $past(int_en))
      else $error("disable read mismatch");
   a_status_on_match: assert property (@(posedge core_clk) disable iff (rst)
      ev_res |-> status == $past(key_idx))
      else $error("status not key index");
   a_status_stable: assert property (@(posedge core_clk) disable iff (rst)
      !ev_res |-> $stable(status))
      else $error("status changed without match");
   a_result_then_end: assert property (@(posedge core_clk) disable iff (rst)
      s_result |-> s_finish)
      else $error("completion missing after result");
   a_one_result: assert property (@(posedge core_clk) disable iff (rst)
      !(ev_res && ev_unres))
      else $error("both result events");
   a_off_no_start: assert property (@(posedge core_clk) disable iff (rst)
      state == IDLE && start_req && enable != ENABLE_ON |=> state == IDLE)
      else $error("started while disabled");
   a_count_range: assert property (@(posedge core_clk) disable iff (rst)
      key_count != 5'h00 && key_count <= KEY_COUNT_MAX)
      else $error("key count out of range");
   a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
      |(events & int_en) |=> irq)
      else $error("interrupt not raised");
   a_stop_on_count: assert property (@(posedge core_clk) disable iff (rst)
      state == MATCH |-> {1'b0, key_idx} < key_count)
      else $error("tried beyond key count");
   a_key_addr: assert property (@(posedge core_clk) disable iff (rst)
      state == SCRATCH && wait_cnt == 16'h0000 && !stop_req |=> mem_addr == key_ptr)
      else $error("first key address wrong");
endmodule : address_resolver

// ===== testbench/resolver_ram.sv
`timescale 1ns/100ps
module resolver_ram
   import resolver_pkg::*;
#(
   parameter logic [31:0] ADDR_BASE = 32'h0000_1000,
   parameter logic [31:0] KEY_BASE = 32'h0000_2000,
   parameter logic [31:0] SCR_BASE = 32'h0000_3000
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic mem_rd,
   input wire logic mem_wr,
   input wire logic [31:0] mem_addr,
   input wire logic [31:0] mem_wdata,
   input wire logic [4:0] hit_key,
   input wire logic [3:0] lat,
   output logic [31:0] mem_rdata,
   output logic mem_valid,
   output int n_rd,
   output int n_bad
);
   // =====================================
   // Contents: address words, one matching key
   function automatic logic [31:0] word(input logic [31:0] a);
      if (a == ADDR_BASE)
         return 32'h1122_3344;
      if (a == ADDR_BASE + 32'h0000_0004)
         return 32'h0000_5566;
      if (a == KEY_BASE + KEY_STRIDE * hit_key)
         return 32'h0077_5555;
      return 32'h0000_0000;
   endfunction : word

   logic bad_rd;
   logic bad_wr;
   logic [31:0] pend;
   logic [3:0] cnt;
   assign bad_rd = mem_rd && !((mem_addr - ADDR_BASE) < 32'h0000_0008 || (mem_addr - KEY_BASE) < 32'h0000_0100);
   // Scratch word must carry the upper address halfword
   assign bad_wr = mem_wr && ((mem_addr - SCR_BASE) >= SCRATCH_SPAN || mem_wdata !== 32'h0000_5566);

   // =====================================
   // Read answer after lat cycles, data toggles when idle
   always_ff @(posedge core_clk)
   begin
      mem_valid <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (rst)
      begin
         cnt <= 4'h0;
         n_rd <= 0;
         n_bad <= 0;
         mem_rdata <= 32'h0000_0000;
      end
      else
      begin
         n_bad <= n_bad + int'(bad_rd) + int'(bad_wr);
         if (mem_rd)
         begin
            n_rd <= n_rd + 1;
            pend <= mem_addr;
            cnt <= lat;
         end
         else if (cnt != 4'h0)
         begin
            cnt <= cnt - 4'h1;
            if (cnt == 4'h1)
            begin
               mem_valid <= 1'b1;
               mem_rdata <= word(pend);
            end
         end
      end
   end
endmodule : resolver_ram

// ===== testbench/address_resolver_tb.sv
`timescale 1ns/100ps
module address_resolver_tb;
   import resolver_pkg::*;
   localparam int OV = 8;
   localparam int KC = 4;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic irq, mem_rd, mem_wr, mem_valid;
   logic [31:0] mem_addr, mem_wdata, mem_rdata;
   logic [4:0] hit_key = 5'h10;
   logic [3:0] lat = 4'h1;
   int n_rd, n_bad;
   int n_errors = 0;
   int checks_done = 0;

   always #5 core_clk = ~core_clk;

   address_resolver #(.OVERHEAD(OV), .KEY_CYCLES(KC)) u_dut (.core_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
      .irq, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .mem_valid);
   resolver_ram u_ram (.core_clk, .rst, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .hit_key, .lat,
      .mem_rdata, .mem_valid, .n_rd, .n_bad);

   // =====================================
   // Tasks
   task automatic summarize;
      if (n_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_cycles(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : wait_cycles

   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask : rd_chk

   // One resolution run, then mask, unmask and clear the end interrupt
   task automatic run(input logic [4:0] n, input logic [4:0] hit, input logic [3:0] l,
      input logic [31:0] pend, input logic [31:0] st, input int reads);
      int cyc;
      int base;
      cyc = 0;
      base = n_rd;
      hit_key <= hit;
      lat <= l;
      wr_reg(OFF_KEY_COUNT, {27'h0, n});
      wr_reg(OFF_START, 32'h0000_0001);
      while (irq !== 1'b1 && cyc < 3000)
      begin
         @(posedge core_clk);
         #1;
         cyc++;
      end
      chk(32'(cyc >= OV + n * KC && cyc < OV + n * (KC + 4 * (l + 3)) + 40), 32'h1);
      chk(32'(n_rd - base), 32'(reads));
      wr_reg(OFF_INT_DISABLE, 32'h0000_0001);
      wait_cycles(3);
      chk({31'h0, irq}, 32'h0);
      wr_reg(OFF_INT_ENABLE_SET, 32'h0000_0001);
      wait_cycles(3);
      chk({31'h0, irq}, 32'h1);
      rd_chk(OFF_PENDING, pend);
      wait_cycles(3);
      chk({31'h0, irq}, 32'h0);
      rd_chk(OFF_STATUS, st);
   endtask : run

   // =====================================
   // Main sequence
   initial
   begin
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      rd_chk(OFF_INT_DISABLE, 32'h0000_0000);
      rd_chk(OFF_STATUS, 32'h0000_0000);
      rd_chk(OFF_ENABLE, 32'h0000_0000);
      rd_chk(OFF_KEY_COUNT, 32'h0000_0001);
      rd_chk(12'h7fc, 32'h0000_0000);
      wr_reg(OFF_KEY_COUNT, 32'h0000_0010);
      wr_reg(OFF_KEY_COUNT, 32'h0000_0000);
      wr_reg(OFF_KEY_COUNT, 32'h0000_0011);
      rd_chk(OFF_KEY_COUNT, 32'h0000_0010);
      wr_reg(OFF_INT_ENABLE_SET, 32'h0000_0007);
      rd_chk(OFF_INT_DISABLE, 32'h0000_0007);
      wr_reg(OFF_INT_DISABLE, 32'h0000_0002);
      rd_chk(OFF_INT_DISABLE, 32'h0000_0005);
      wr_reg(OFF_INT_DISABLE, 32'h0000_0000);
      rd_chk(OFF_INT_DISABLE, 32'h0000_0005);
      wr_reg(OFF_INT_DISABLE, 32'h0000_0004);
      rd_chk(OFF_INT_DISABLE, 32'h0000_0001);
      wr_reg(OFF_KEY_PTR, 32'h0000_2000);
      wr_reg(OFF_ADDR_PTR, 32'h0000_1000);
      wr_reg(OFF_SCRATCH_PTR, 32'h0000_3000);
      rd_chk(OFF_KEY_PTR, 32'h0000_2000);
      rd_chk(OFF_ADDR_PTR, 32'h0000_1000);
      rd_chk(OFF_SCRATCH_PTR, 32'h0000_3000);
      // Start while switched off does nothing
      wr_reg(OFF_START, 32'h0000_0001);
      wait_cycles(60);
      chk({31'h0, irq}, 32'h0);
      chk(32'(n_rd), 32'h0);
      wr_reg(OFF_ENABLE, 32'h0000_0003);
      rd_chk(OFF_ENABLE, 32'h0000_0003);
      run(5'h03, 5'h02, 4'h1, 32'h0000_0003, 32'h0000_0002, 14);
      run(5'h10, 5'h10, 4'h3, 32'h0000_0005, 32'h0000_0002, 66);
      run(5'h01, 5'h00, 4'h2, 32'h0000_0003, 32'h0000_0000, 6);
      // Stop in mid-run raises only the end event
      wr_reg(OFF_START, 32'h0000_0001);
      wr_reg(OFF_STOP, 32'h0000_0001);
      wait_cycles(3);
      rd_chk(OFF_EV_RESOLVED, 32'h0000_0000);
      rd_chk(OFF_EV_UNRESOLVED, 32'h0000_0000);
      rd_chk(OFF_EV_END, 32'h0000_0001);
      rd_chk(OFF_EV_END, 32'h0000_0000);
      chk({31'h0, irq}, 32'h0);
      rd_chk(OFF_STATUS, 32'h0000_0000);
      chk(32'(OVERHEAD_CYCLES + 8 * PER_KEY_CYCLES > 4700 && OVERHEAD_CYCLES + 8 * PER_KEY_CYCLES < 4900), 32'h1);
      chk(32'(n_bad), 32'h0);
      wr_reg(OFF_ENABLE, 32'h0000_0000);
      rd_chk(OFF_ENABLE, 32'h0000_0000);
      summarize();
   end

   initial
   begin
      #300000;
      n_errors++;
      summarize();
   end
endmodule : address_resolver_tb
